// *** hw/retimer_channel_eq_control.sv ***
// per-channel equalizer, routing, ppm and fir control of the retimer data path
module retimer_channel_eq_control
  import retimer_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sig_detect_pin,
  input wire logic sd_override_en,
  input wire logic sd_override_val,
  output logic power_on,
  input wire logic rec_lock,
  input wire logic rec_reset,
  input wire logic readapt,
  input wire logic [7:0] horizontal_eye_opening,
  input wire logic [7:0] vertical_eye_opening,
  output logic [7:0] boost,
  output logic vga_gain,
  output logic eq_dc_gain,
  input wire logic own_data,
  input wire logic partner_data,
  input wire logic xp_enable,
  input wire logic xp_take_partner,
  output logic rec_data,
  input wire fb_ctrl_t fb_ctrl,
  input wire logic [24:0] fb_manual_weight,
  input wire logic [4:0] fb_manual_pol,
  input wire logic fb_err_valid,
  input wire logic [4:0] fb_err_up,
  input wire logic [4:0] fb_err_down,
  output logic [4:0] fb_tap_on,
  output logic [24:0] fb_weight,
  output logic [4:0] fb_pol,
  input wire out_mode_t out_mode,
  input wire logic checker_route,
  input wire logic bit_valid,
  input wire logic retimed_bit,
  input wire logic raw_bit,
  input wire logic pattern_bit,
  output logic checker_data,
  input wire logic cal_clk_pin,
  input wire logic vco_tick,
  input wire logic [15:0] rate_expected,
  input wire logic [15:0] rate_tolerance,
  output logic rate_ok,
  input wire fir_coef_t fir_coef,
  output logic signed [7:0] fir_level,
  output logic [6:0] swing_pp
);

  logic [7:0] boost_table_reg [BOOST_ENTRIES];
  logic [7:0] eq_gain_reg;
  logic [7:0] gain_amp_reg;
  logic [7:0] rdata_reg;
  logic [2:0] sd_sync_reg;
  logic sd_lvl_reg;
  logic power_reg;
  adapt_state_t state_reg;
  logic [3:0] idx_reg;
  logic [4:0] settle_reg;
  logic [8:0] best_merit_reg;
  logic [3:0] best_idx_reg;
  logic [7:0] boost_reg;
  logic [8:0] merit;
  logic [3:0] winner_idx;
  logic step_done;
  logic rec_data_reg;
  logic [4:0] tap_w_reg [FB_TAPS];
  logic [4:0] tap_on_reg;
  logic [24:0] fb_weight_reg;
  logic [4:0] fb_pol_reg;
  logic [4:0] tap_mask;
  logic fb_adapting;
  logic [2:0] tx_bits_reg;
  logic tx_bit;
  logic checker_reg;
  logic signed [7:0] fir_level_reg;
  logic [6:0] swing_reg;
  logic [2:0] cal_sync_reg;
  logic cal_lvl_reg;
  logic cal_rise;
  logic [15:0] cal_edges_reg;
  logic [15:0] vco_count_reg;
  logic rate_ok_reg;
  logic window_end;

  // register port: writes take effect at the edge, reads answer one cycle later
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eq_gain_reg <= EQ_GAIN_RESET;
      gain_amp_reg <= GAIN_AMP_RESET;
      for (int i = 0; i < BOOST_ENTRIES; i++)
        boost_table_reg[i] <= BOOST_ENTRY_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_EQ_GAIN)
        eq_gain_reg <= reg_wdata;
      if (reg_addr == ADDR_GAIN_AMP)
        gain_amp_reg <= reg_wdata;
      if (reg_addr >= ADDR_BOOST_FIRST && reg_addr <= ADDR_BOOST_LAST)
        boost_table_reg[reg_addr[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_EQ_GAIN)
        rdata_reg <= eq_gain_reg;
      else if (reg_addr == ADDR_GAIN_AMP)
        rdata_reg <= gain_amp_reg;
      else if (reg_addr >= ADDR_BOOST_FIRST && reg_addr <= ADDR_BOOST_LAST)
        rdata_reg <= boost_table_reg[reg_addr[3:0]];
      else if (reg_addr == ADDR_ADAPT_STATUS)
        rdata_reg <= {state_reg, best_idx_reg};
      else
        rdata_reg <= 8'h00;
    end
  end

  // signal detect pin: three flops, level taken once the last two agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sd_sync_reg <= 3'h0;
      sd_lvl_reg <= 1'b0;
      power_reg <= 1'b0;
    end
    else
    begin
      sd_sync_reg <= {sd_sync_reg[1:0], sig_detect_pin};
      if (sd_sync_reg[1] == sd_sync_reg[2])
        sd_lvl_reg <= sd_sync_reg[2];
      power_reg <= sd_override_en ? sd_override_val : sd_lvl_reg;
    end
  end

  // figure of merit weights both eye openings equally
  assign merit = {1'b0, horizontal_eye_opening} + {1'b0, vertical_eye_opening};
  assign step_done = (settle_reg == SETTLE_LAST);
  assign winner_idx = (merit > best_merit_reg || idx_reg == 4'h0) ? idx_reg : best_idx_reg;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_OFF;
      idx_reg <= 4'h0;
      settle_reg <= 5'h00;
      best_merit_reg <= 9'h000;
      best_idx_reg <= 4'h0;
      boost_reg <= 8'h00;
    end
    else if (!power_reg)
      state_reg <= ST_OFF;
    else
    begin
      case (state_reg)
        ST_OFF:
        begin
          state_reg <= ST_SEARCH;
          idx_reg <= 4'h0;
          settle_reg <= 5'h00;
        end
        ST_SEARCH:
        begin
          boost_reg <= boost_table_reg[idx_reg];
          settle_reg <= step_done ? 5'h00 : settle_reg + 5'h01;
          if (step_done)
          begin
            best_idx_reg <= winner_idx;
            best_merit_reg <= (winner_idx == idx_reg) ? merit : best_merit_reg;
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == 4'hF)
            begin
              boost_reg <= boost_table_reg[winner_idx];
              state_reg <= ST_WAIT_LOCK;
            end
          end
        end
        ST_WAIT_LOCK:
          if (rec_reset)
            state_reg <= ST_OFF;
          else if (rec_lock)
            state_reg <= ST_FROZEN;
        ST_FROZEN:
          // boost held; any of these restarts the search
          if (readapt || rec_reset || !rec_lock)
            state_reg <= ST_OFF;
        default:
          state_reg <= ST_OFF;
      endcase
    end
  end

  // cross-point: partner data is taken only when this channel's xp_enable and xp_take_partner are both set
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rec_data_reg <= 1'b0;
    else
      rec_data_reg <= (xp_enable && xp_take_partner) ? partner_data : own_data;
  end

  always_comb
  begin
    case (fb_ctrl.extent)
      FB_ALL: tap_mask = TAPS_ALL_MASK;
      FB_TAPS12: tap_mask = TAPS12_MASK;
      default: tap_mask = 5'h00;
    endcase
    if (!fb_ctrl.enable)
      tap_mask = 5'h00;
  end

  assign fb_adapting = fb_ctrl.enable && fb_ctrl.adapt_en &&
    (fb_ctrl.continuous || state_reg == ST_SEARCH);

  // manual taps only load while adaptation is off, so the two never fight
  for (genvar t = 0; t < FB_TAPS; t++)
  begin : g_tap
    localparam logic [4:0] TAP_MAX = (t == 0) ? TAP1_MAX : TAPN_MAX;
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        tap_w_reg[t] <= 5'h00;
        fb_weight_reg[5*t +: 5] <= 5'h00;
        fb_pol_reg[t] <= 1'b0;
      end
      else
      begin
        if (!fb_ctrl.adapt_en)
          tap_w_reg[t] <= (fb_manual_weight[5*t +: 5] > TAP_MAX) ? TAP_MAX : fb_manual_weight[5*t +: 5];
        else if (fb_adapting && fb_err_valid)
        begin
          if (fb_err_up[t] && tap_w_reg[t] < TAP_MAX)
            tap_w_reg[t] <= tap_w_reg[t] + 5'h01;
          else if (fb_err_down[t] && tap_w_reg[t] != 5'h00)
            tap_w_reg[t] <= tap_w_reg[t] - 5'h01;
        end
        fb_weight_reg[5*t +: 5] <= tap_mask[t] ? tap_w_reg[t] : 5'h00;
        fb_pol_reg[t] <= tap_mask[t] & fb_manual_pol[t];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tap_on_reg <= 5'h00;
    else
      tap_on_reg <= tap_mask;
  end

  always_comb
  begin
    case (out_mode)
      OUT_RETIMED: tx_bit = retimed_bit;
      OUT_RAW: tx_bit = raw_bit;
      OUT_PATTERN: tx_bit = pattern_bit;
      default: tx_bit = 1'b0;
    endcase
  end

  function automatic logic signed [7:0] tap_term(input logic signed [7:0] c, input logic b);
    tap_term = b ? c : -c;
  endfunction

  function automatic logic [6:0] mag(input logic signed [7:0] c);
    mag = c[7] ? 7'(-c) : c[6:0];
  endfunction

  logic signed [7:0] c_pre;
  logic signed [7:0] c_main;
  logic signed [7:0] c_post;
  assign c_pre = {{3{fir_coef.pre[4]}}, fir_coef.pre};
  assign c_main = {{2{fir_coef.main[5]}}, fir_coef.main};
  assign c_post = {{3{fir_coef.post[4]}}, fir_coef.post};

  // bit 0 of tx_bits_reg is the next bit, bit 1 the current, bit 2 the previous
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_bits_reg <= 3'h0;
      fir_level_reg <= 8'sh00;
      swing_reg <= 7'h00;
      checker_reg <= 1'b0;
    end
    else
    begin
      if (bit_valid)
        tx_bits_reg <= {tx_bits_reg[1:0], tx_bit};
      if (out_mode == OUT_MUTE)
        fir_level_reg <= 8'sh00;
      else
        fir_level_reg <= tap_term(c_pre, tx_bits_reg[0]) + tap_term(c_main, tx_bits_reg[1]) +
          tap_term(c_post, tx_bits_reg[2]);
      swing_reg <= mag(c_pre) + mag(c_main) + mag(c_post);
      checker_reg <= checker_route & retimed_bit;
    end
  end

  // calibration clock as a sampled level; slow enough only once divided outside
  assign cal_rise = (cal_sync_reg[1] == cal_sync_reg[2]) && cal_sync_reg[2] && !cal_lvl_reg;
  assign window_end = cal_rise && (cal_edges_reg == PPM_WINDOW_EDGES - 16'h0001);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_sync_reg <= 3'h0;
      cal_lvl_reg <= 1'b0;
      cal_edges_reg <= 16'h0000;
      vco_count_reg <= 16'h0000;
      rate_ok_reg <= 1'b0;
    end
    else
    begin
      cal_sync_reg <= {cal_sync_reg[1:0], cal_clk_pin};
      if (cal_sync_reg[1] == cal_sync_reg[2])
        cal_lvl_reg <= cal_sync_reg[2];
      if (window_end)
      begin
        cal_edges_reg <= 16'h0000;
        vco_count_reg <= 16'h0000;
        rate_ok_reg <= (vco_count_reg + rate_tolerance >= rate_expected) &&
          (vco_count_reg <= rate_expected + rate_tolerance);
      end
      else
      begin
        if (cal_rise)
          cal_edges_reg <= cal_edges_reg + 16'h0001;
        if (vco_tick && vco_count_reg != 16'hFFFF)
          vco_count_reg <= vco_count_reg + 16'h0001;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign power_on = power_reg;
  assign boost = boost_reg;
  assign vga_gain = gain_amp_reg[GAIN_AMP_BIT];
  assign eq_dc_gain = eq_gain_reg[EQ_DC_GAIN_BIT];
  assign rec_data = rec_data_reg;
  assign fb_tap_on = tap_on_reg;
  assign fb_weight = fb_weight_reg;
  assign fb_pol = fb_pol_reg;
  assign checker_data = checker_reg;
  assign rate_ok = rate_ok_reg;
  assign fir_level = fir_level_reg;
  assign swing_pp = swing_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_detect_power;
    !sd_override_en && !power_reg && sd_lvl_reg |=> power_reg;
  endproperty
  a_detect_power: assert property (p_detect_power) else $error("power did not follow detect");

  property p_override;
    sd_override_en ##1 sd_override_en |-> power_reg == $past(sd_override_val);
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_frozen_hold;
    state_reg == ST_FROZEN |=> $stable(boost_reg);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("boost moved while frozen");

  property p_readapt;
    power_reg && state_reg == ST_FROZEN && readapt |=> state_reg == ST_OFF ##1 state_reg == ST_SEARCH;
  endproperty
  a_readapt: assert property (p_readapt) else $error("re-adapt not started");

  property p_pick_best;
    $rose(state_reg == ST_WAIT_LOCK) && !$past(reg_wr) |-> boost_reg == boost_table_reg[best_idx_reg];
  endproperty
  a_pick_best: assert property (p_pick_best) else $error("winner not applied");

  property p_vga_write;
    reg_wr && reg_addr == ADDR_GAIN_AMP |=> vga_gain == $past(reg_wdata[GAIN_AMP_BIT]);
  endproperty
  a_vga_write: assert property (p_vga_write) else $error("gain bit not written");

  // tap enables, weights and polarities all register from the same edge
  property p_fb_off;
    !fb_ctrl.enable |=> tap_on_reg == 5'h00 && fb_weight_reg == 25'h000_0000 && fb_pol_reg == 5'h00;
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("feedback taps on while disabled");

  property p_fb_taps12;
    fb_ctrl.enable && fb_ctrl.extent == FB_TAPS12 |=> tap_on_reg == TAPS12_MASK;
  endproperty
  a_fb_taps12: assert property (p_fb_taps12) else $error("wrong tap extent");

  property p_tap_range;
    tap_w_reg[1] <= TAPN_MAX && tap_w_reg[4] <= TAPN_MAX;
  endproperty
  a_tap_range: assert property (p_tap_range) else $error("tap weight out of range");

  property p_mute;
    out_mode == OUT_MUTE |=> fir_level_reg == 8'sh00;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not silent");

  property p_ppm_window;
    $changed(rate_ok_reg) |-> $past(window_end);
  endproperty
  a_ppm_window: assert property (p_ppm_window) else $error("rate flag moved off window");

  c_search_done: cover property ($rose(state_reg == ST_WAIT_LOCK));
  c_frozen: cover property (state_reg == ST_WAIT_LOCK ##1 state_reg == ST_FROZEN);
  c_rate_ok: cover property ($rose(rate_ok_reg));
  c_fb_step: cover property (fb_adapting && fb_err_valid && |fb_err_up);

endmodule // retimer_channel_eq_control

// *** hw/retimer_pkg.sv ***
// constants and types for the retimer channel control block
package retimer_pkg;
  // channel register offsets
  localparam logic [7:0] ADDR_EQ_GAIN = 8'h13;
  localparam logic [7:0] ADDR_BOOST_FIRST = 8'h40;
  localparam logic [7:0] ADDR_BOOST_LAST = 8'h4F;
  localparam logic [7:0] ADDR_GAIN_AMP = 8'h8E;
  localparam logic [7:0] ADDR_ADAPT_STATUS = 8'h90;
  // field positions
  localparam int EQ_DC_GAIN_BIT = 5;
  localparam int GAIN_AMP_BIT = 0;
  // reset values
  localparam logic [7:0] EQ_GAIN_RESET = 8'h00;
  localparam logic [7:0] GAIN_AMP_RESET = 8'h00;
  localparam logic [7:0] BOOST_ENTRY_RESET = 8'h00;
  // boost table shape
  localparam int BOOST_ENTRIES = 16;
  localparam int BOOST_STAGES = 4;
  localparam int STAGE_BITS = 2;
  // timing
  localparam int CLOCK_KHZ = 20_000;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLOCK_KHZ + 999_999) / 1_000_000;
  localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CYCLES - 1);
  localparam logic [15:0] PPM_WINDOW_EDGES = 16'h00FA;
  // feedback equalizer
  localparam int FB_TAPS = 5;
  localparam logic [4:0] TAP1_MAX = 5'h1F;
  localparam logic [4:0] TAPN_MAX = 5'h0F;
  localparam logic [4:0] TAPS12_MASK = 5'h03;
  localparam logic [4:0] TAPS_ALL_MASK = 5'h1F;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_SEARCH = 4'b0010,
    ST_WAIT_LOCK = 4'b0100,
    ST_FROZEN = 4'b1000
  } adapt_state_t;

  typedef enum logic [1:0] {
    OUT_RETIMED = 2'h0,
    OUT_RAW = 2'h1,
    OUT_PATTERN = 2'h2,
    OUT_MUTE = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    FB_ALL = 2'h0,
    FB_TAPS12 = 2'h1,
    FB_NONE = 2'h2
  } fb_extent_t;

  typedef struct packed {
    logic enable;
    logic adapt_en;
    logic continuous;
    fb_extent_t extent;
  } fb_ctrl_t;

  typedef struct packed {
    logic signed [4:0] pre;
    logic signed [5:0] main;
    logic signed [4:0] post;
  } fir_coef_t;
endpackage

// *** verification/link_partner_model.sv ***
// link partner model: energy detect, eye measures, calibration clock and vco ticks
module link_partner_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic signal_present,
  input wire logic [7:0] boost,
  output logic sig_detect_pin,
  output logic [7:0] horizontal_eye_opening,
  output logic [7:0] vertical_eye_opening,
  output logic cal_clk_pin,
  output logic vco_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  parameter int CAL_HALF_NS = 250;
  parameter int TICK_EVERY = 5;
  int tick_count;

  // detector output lags the line, so it is never aligned to the system clock
  assign #13 sig_detect_pin = signal_present;

  // more boost opens the eye wider here, so the best entry is the largest one
  assign horizontal_eye_opening = boost;
  assign vertical_eye_opening = 8'h10;

  // pre-divided calibration clock, phase unrelated to the system clock
  initial
  begin
    cal_clk_pin = 1'b0;
    #37;
    forever #(CAL_HALF_NS) cal_clk_pin = ~cal_clk_pin;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_count <= 0;
      vco_tick <= 1'b0;
    end
    else
    begin
      tick_count <= (tick_count == TICK_EVERY - 1) ? 0 : tick_count + 1;
      vco_tick <= (tick_count == TICK_EVERY - 1);
    end
  end
endmodule // link_partner_model

// *** verification/tb_retimer_channel_eq_control.sv ***
// self-checking bench for the retimer channel control block
module tb_retimer_channel_eq_control
  import retimer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, reg_wr, reg_rd, signal_present, sig_detect_pin, sd_override_en, sd_override_val, power_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, horizontal_eye_opening, vertical_eye_opening, boost, rd, s;
  logic rec_lock, rec_reset, readapt, vga_gain, eq_dc_gain, own_data, partner_data, xp_enable, xp_take_partner;
  logic rec_data, fb_err_valid, checker_route, bit_valid, retimed_bit, raw_bit, pattern_bit, checker_data;
  logic cal_clk_pin, vco_tick, rate_ok;
  fb_ctrl_t fb_ctrl;
  logic [24:0] fb_manual_weight, fb_weight;
  logic [4:0] fb_manual_pol, fb_err_up, fb_err_down, fb_tap_on, fb_pol, mask;
  out_mode_t out_mode;
  logic [15:0] rate_expected, rate_tolerance;
  fir_coef_t fir_coef;
  logic signed [7:0] fir_level;
  logic [6:0] swing_pp;
  int failures, check_count, cycles;

  retimer_channel_eq_control retimer_channel_eq_control_inst (.clock, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .sig_detect_pin, .sd_override_en, .sd_override_val, .power_on, .rec_lock, .rec_reset,
    .readapt, .horizontal_eye_opening, .vertical_eye_opening, .boost, .vga_gain, .eq_dc_gain, .own_data,
    .partner_data, .xp_enable, .xp_take_partner, .rec_data, .fb_ctrl, .fb_manual_weight, .fb_manual_pol,
    .fb_err_valid, .fb_err_up, .fb_err_down, .fb_tap_on, .fb_weight, .fb_pol, .out_mode, .checker_route,
    .bit_valid, .retimed_bit, .raw_bit, .pattern_bit, .checker_data, .cal_clk_pin, .vco_tick, .rate_expected,
    .rate_tolerance, .rate_ok, .fir_coef, .fir_level, .swing_pp);
  link_partner_model link_partner_model_inst (.clock, .rst_n, .signal_present, .boost, .sig_detect_pin,
    .horizontal_eye_opening, .vertical_eye_opening, .cal_clk_pin, .vco_tick);

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // polls the status register; a hang shows up as a later mismatch
  task automatic wait_status(input logic [7:0] m);
    int n;
    n = 0;
    rd_reg(ADDR_ADAPT_STATUS, s);
    while ((s & m) == 8'h00 && n < 800)
    begin
      rd_reg(ADDR_ADAPT_STATUS, s);
      n++;
    end
  endtask

  task automatic shift_bits(input int n);
    repeat (n)
    begin
      @(posedge clock);
      bit_valid <= 1'b1;
      @(posedge clock);
      bit_valid <= 1'b0;
    end
    settle(2);
  endtask

  task automatic pulse_err();
    @(posedge clock);
    fb_err_valid <= 1'b1;
    @(posedge clock);
    fb_err_valid <= 1'b0;
    settle(3);
  endtask

  function automatic logic [7:0] tbl(input int i);
    return (i == 9) ? 8'hF0 : 8'(i * 5);
  endfunction

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, signal_present, sd_override_en, sd_override_val, rec_lock, rec_reset, readapt} = '0;
    {own_data, partner_data, xp_enable, xp_take_partner, fb_err_valid, checker_route, bit_valid} = '0;
    {retimed_bit, raw_bit, pattern_bit, reg_addr, reg_wdata, fb_manual_weight, fb_manual_pol} = '0;
    {fb_err_up, fb_err_down, rate_expected, rate_tolerance, fir_coef, fb_ctrl} = '0;
    out_mode = OUT_RETIMED;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(ADDR_GAIN_AMP, rd);
    check("gain amp reg", rd, GAIN_AMP_RESET);
    check("vga gain", vga_gain, 1'b0);
    wr_reg(ADDR_GAIN_AMP, 8'h01);
    rd_reg(ADDR_GAIN_AMP, rd);
    check("gain amp reg", rd, 8'h01);
    check("vga gain", vga_gain, 1'b1);
    rd_reg(ADDR_EQ_GAIN, rd);
    check("eq gain reg", rd, EQ_GAIN_RESET);
    wr_reg(ADDR_EQ_GAIN, 8'h20);
    rd_reg(ADDR_EQ_GAIN, rd);
    check("eq gain reg", rd, 8'h20);
    check("eq dc gain", eq_dc_gain, 1'b1);
    wr_reg(ADDR_GAIN_AMP, 8'h00);
    settle(1);
    check("eq dc gain kept", eq_dc_gain, 1'b1);
    wr_reg(8'h77, 8'hA5);
    rd_reg(8'h77, rd);
    check("unmapped", rd, 8'h00);
    for (int i = 0; i < BOOST_ENTRIES; i++)
    begin
      rd_reg(ADDR_BOOST_FIRST + 8'(i), rd);
      check("table reset", rd, BOOST_ENTRY_RESET);
      wr_reg(ADDR_BOOST_FIRST + 8'(i), tbl(i));
      rd_reg(ADDR_BOOST_FIRST + 8'(i), rd);
      check("table entry", rd, tbl(i));
    end
    $display("test registers done");
    @(posedge clock);
    signal_present <= 1'b1;
    settle(10);
    check("power on", power_on, 1'b1);
    wait_status(8'h40);
    check("best boost", boost, 8'hF0);
    check("best index", s[3:0], 4'h9);
    @(posedge clock);
    rec_lock <= 1'b1;
    wr_reg(ADDR_BOOST_FIRST + 8'h09, 8'h01);
    settle(40);
    rd_reg(ADDR_ADAPT_STATUS, s);
    check("frozen state", s[7:4], 4'h8);
    check("frozen boost", boost, 8'hF0);
    @(posedge clock);
    readapt <= 1'b1;
    @(posedge clock);
    readapt <= 1'b0;
    settle(5);
    wait_status(8'hC0);
    check("readapt boost", boost, 8'h4B);
    @(posedge clock);
    rec_reset <= 1'b1;
    @(posedge clock);
    rec_reset <= 1'b0;
    settle(3);
    rd_reg(ADDR_ADAPT_STATUS, s);
    check("search after reset", s[7:4], 4'h2);
    $display("test adaptation done");
    @(posedge clock);
    sd_override_en <= 1'b1;
    sd_override_val <= 1'b0;
    settle(3);
    check("forced off", power_on, 1'b0);
    rd_reg(ADDR_ADAPT_STATUS, s);
    check("off state", s[7:4], 4'h1);
    @(posedge clock);
    sd_override_val <= 1'b1;
    settle(3);
    check("forced on", power_on, 1'b1);
    @(posedge clock);
    sd_override_en <= 1'b0;
    signal_present <= 1'b0;
    settle(8);
    check("no signal", power_on, 1'b0);
    $display("test power done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock);
      {xp_enable, xp_take_partner} <= 2'(k);
      own_data <= k[0];
      partner_data <= ~k[0];
      settle(2);
      check("cross point", rec_data, (k == 3) ? 1'b0 : k[0]);
    end
    @(posedge clock);
    fb_manual_weight <= {5'h0F, 5'h0F, 5'h0F, 5'h1F, 5'h1F};
    fb_manual_pol <= 5'h15;
    settle(3);
    check("feedback off", fb_tap_on, 5'h00);
    for (int e = 0; e < 3; e++)
    begin
      @(posedge clock);
      fb_ctrl <= '{1'b1, 1'b0, 1'b0, fb_extent_t'(e)};
      settle(3);
      mask = (e == 0) ? TAPS_ALL_MASK : (e == 1) ? TAPS12_MASK : 5'h00;
      check("tap enable", fb_tap_on, mask);
      check("tap weight", fb_weight, {5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h1F} & {{5{mask[4]}}, {5{mask[3]}},
        {5{mask[2]}}, {5{mask[1]}}, {5{mask[0]}}});
      check("tap polarity", fb_pol, 5'h15 & mask);
    end
    @(posedge clock);
    fb_ctrl <= '{1'b1, 1'b1, 1'b1, FB_ALL};
    fb_err_down <= 5'h01;
    pulse_err();
    check("continuous step", fb_weight[4:0], 5'h1E);
    @(posedge clock);
    fb_ctrl <= '{1'b1, 1'b1, 1'b0, FB_ALL};
    pulse_err();
    check("no step when locked", fb_weight[4:0], 5'h1E);
    $display("test cross point and feedback done");
    @(posedge clock);
    fir_coef <= '{5'sd0, 6'sd10, 5'sd0};
    retimed_bit <= 1'b1;
    pattern_bit <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clock);
      out_mode <= out_mode_t'(m);
      shift_bits(3);
      check("output mode", fir_level, (m == 3) ? 8'sd0 : (m == 1) ? -8'sd10 : 8'sd10);
    end
    // boost shape: pre and post against main, absolute sum 15
    @(posedge clock);
    out_mode <= OUT_RETIMED;
    fir_coef <= '{-5'sd2, 6'sd10, -5'sd3};
    shift_bits(3);
    check("fir ones", fir_level, 8'sd5);
    check("fir swing", swing_pp, 7'd15);
    @(posedge clock);
    retimed_bit <= 1'b0;
    shift_bits(3);
    check("fir zeros", fir_level, -8'sd5);
    @(posedge clock);
    retimed_bit <= 1'b1;
    shift_bits(1);
    check("fir edge", fir_level, -8'sd9);
    @(posedge clock);
    checker_route <= 1'b1;
    settle(2);
    check("checker path", checker_data, 1'b1);
    @(posedge clock);
    checker_route <= 1'b0;
    settle(2);
    check("checker off", checker_data, 1'b0);
    $display("test fir and output done");
    @(posedge clock);
    rate_expected <= 16'h01F4;
    rate_tolerance <= 16'h0002;
    settle(5200);
    check("rate in range", rate_ok, 1'b1);
    @(posedge clock);
    rate_expected <= 16'h0064;
    settle(5200);
    check("rate out of range", rate_ok, 1'b0);
    $display("test ppm done");
    end_sim();
  end
endmodule // tb_retimer_channel_eq_control
